// *** mcisd_master.sv ***
// Purpose: I2C master model that drives the decoder's bus
// Assumes: Bench resolves both open-drain wires with pull-ups
// Notes: Bit period 8 sys_clk (80 ns), low 6 / high 2; waits out clock stretch
module mcisd_master (
  // Clock
  input wire logic sys_clk,
  // Resolved bus wires
  input wire logic scl,
  input wire logic sda,
  // Pull-downs, high pulls the wire low
  output logic scl_low,
  output logic sda_low,
  // Status seen by the bench
  output logic hung,
  output int stretch_cnt
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bus released at time zero
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    hung = 1'b0;
    stretch_cnt = 0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wait a number of clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Release SCL and wait while the device holds it; bounded so a stuck bus ends the run
  task automatic rise();
    int i;
    scl_low <= 1'b0;
    for (i = 0; i < 3000; i++) begin
      if (i >= 0) @(posedge sys_clk);
      if (scl === 1'b1) break;
    end
    if (i > 0) stretch_cnt++;
    if (i == 3000) hung <= 1'b1;
  endtask : rise

  // One bit; a released bit reads the wire at the end of the high phase
  task automatic xfer_bit(input logic b, output logic got);
    tick(3);
    sda_low <= ~b;
    tick(3);
    rise();
    tick(1);
    got = sda;
    scl_low <= 1'b1;
  endtask : xfer_bit

  // Byte out, MSB first, then the device's acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic g;
    int k;
    for (k = 7; k >= 0; k--) xfer_bit(d[k], g);
    xfer_bit(1'b1, g);
    ack = ~g;
  endtask : wr_byte

  // Byte in; the last byte of a read is answered with NACK
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic g;
    int k;
    for (k = 7; k >= 0; k--) begin
      xfer_bit(1'b1, g);
      d[k] = g;
    end
    xfer_bit(last, g);
  endtask : rd_byte

  // Start or repeated start; long low lead lets the device drop its ACK first
  task automatic start();
    sda_low <= 1'b0;
    tick(5);
    rise();
    tick(3);
    sda_low <= 1'b1;
    tick(3);
    scl_low <= 1'b1;
  endtask : start

  // Stop condition
  task automatic stop();
    sda_low <= 1'b1;
    tick(5);
    rise();
    tick(3);
    sda_low <= 1'b0;
    tick(6);
  endtask : stop

  // Quiet bus for 100 us after a read at this fast rate
  task automatic idle_long();
    tick(10000);
  endtask : idle_long

endmodule : mcisd_master

// *** mcisd_params.svh ***
// Purpose: Constants for the motor command I2C slave decoder
// Assumes: 100 MHz system clock
// Notes: Offsets, commands, reset values and timing counts
`ifndef MCISD_PARAMS_SVH
`define MCISD_PARAMS_SVH

// Default device number; its low 7 bits form the address
`define MCISD_DEV_NUM_RST 14'h000B
// Command bytes
`define MCISD_CMD_HIRES 8'hC0
`define MCISD_CMD_LOWREV 8'hE0
`define MCISD_CMD_LOWFWD 8'hE1
`define MCISD_CMD_GETVAR 8'hE5
`define MCISD_CMD_GETRAM 8'hEA
`define MCISD_CMD_FDUTYT 8'hF2
`define MCISD_CMD_FDUTY 8'hF4
// Target arithmetic
`define MCISD_TGT_MID 12'h800
`define MCISD_OPEN_NUM 17'h0_0258
`define MCISD_OPEN_DEN 17'h0_007F
// Longest read response in bytes
`define MCISD_RD_MAX 4'hF
// Clock stretch time and its cycle count
`define MCISD_CLK_NS 10
`define MCISD_STRETCH_NS 1000
`define MCISD_STRETCH_CYC ((`MCISD_STRETCH_NS) / (`MCISD_CLK_NS))

`endif

// *** mcisd_pkg.sv ***
// Purpose: Types for the motor command I2C slave decoder
// Assumes: Nothing beyond the params header
// Notes: Structs carry grouped outputs
package mcisd_pkg;

  // Feedback mode of the controller
  typedef enum logic [1:0] {
    FB_NONE,
    FB_ANALOG,
    FB_FREQ
  } mcisd_fb_e;

  // Byte engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK,
    ST_LOAD
  } mcisd_st_e;

  // Target update
  typedef struct packed {
    logic valid;
    logic [11:0] value;
  } mcisd_tgt_s;

  // Duty cycle force; hold=1 for the target form
  typedef struct packed {
    logic valid;
    logic hold;
    logic [15:0] value;
  } mcisd_duty_s;

  // Variable read request
  typedef struct packed {
    logic space;
    logic [7:0] addr;
  } mcisd_rdreq_s;

endpackage : mcisd_pkg

// *** mcisd_top.sv ***
// Purpose: I2C slave decoding motor target and duty commands
// Assumes: SCL and SDA arrive async; rd_data follows rd_req
// Notes: SCL is sampled by sys_clk, stretched at most once per byte
// Function
// - Address is low 7 bits of device number
// - First byte is address plus direction bit
// - Repeated start handled as stop plus start
// - Acknowledge matching address and following bytes
// - High-res command byte carries target low 5
// - Data byte holds target bits 5 to 11
// - Target updates when final byte is acknowledged
// - Analog/frequency forward: 2048 plus 16 times magnitude
// - Open-loop forward: 2048 plus 600/127 magnitude
// - Reverse subtracts scaled magnitude from 2048
// - Reverse with zero magnitude stops motor
// - Command F2 takes signed 16-bit, low first
// - Command F4 uses the same encoding
// - Variable read returns bytes from offset
// - At most 15 response bytes per read
// - Multi-byte variables go least significant first
// - Command-only write then read reuses offset
// - Variable read E5, RAM settings read EA
// - Stretch SCL at most once per byte
`include "mcisd_params.svh"

module mcisd_top
  import mcisd_pkg::*;
#(
  parameter int STRETCH_CYC = `MCISD_STRETCH_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // I2C clock pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // I2C data pin
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Settings
  input wire logic dev_num_wr,
  input wire logic [13:0] dev_num_in,
  input wire mcisd_fb_e fb_mode,
  // Motor commands
  output mcisd_tgt_s tgt_cmd,
  output logic stop_pulse,
  output mcisd_duty_s duty_cmd,
  // Variable read port
  output mcisd_rdreq_s rd_req,
  input wire logic [7:0] rd_data
);

  // Stretch counter must fit its 10-bit register
  if (STRETCH_CYC < 1 || STRETCH_CYC > 1000) begin : g_chk
    $error("STRETCH_CYC out of range");
  end

  ////////////////////////////////////////////////////////////
  // Functions

  // High-resolution group covers C0 to DF
  function automatic logic is_hires(input logic [7:0] c);
    is_hires = (c[7:5] == 3'(`MCISD_CMD_HIRES >> 5));
  endfunction : is_hires

  // Either force-duty command
  function automatic logic is_duty(input logic [7:0] c);
    is_duty = (c == `MCISD_CMD_FDUTYT) || (c == `MCISD_CMD_FDUTY);
  endfunction : is_duty

  // Low-resolution target from magnitude and mode
  function automatic logic [11:0] low_tgt(input logic rev,
                                          input mcisd_fb_e m,
                                          input logic [6:0] mag);
    logic [16:0] prod;
    logic [11:0] sc;
    prod = {10'h000, mag} * `MCISD_OPEN_NUM;
    sc = {1'b0, mag, 4'h0};
    if (m == FB_NONE) begin
      // Truncating divide; 127 maps exactly to 600
      sc = 12'(prod / `MCISD_OPEN_DEN);
    end
    low_tgt = rev ? `MCISD_TGT_MID - sc : `MCISD_TGT_MID + sc;
  endfunction : low_tgt

  ////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0] sy1_ff; // First sync stage {sda, scl}
  logic [1:0] sy2_ff; // Second sync stage
  logic [1:0] prv_ff; // Previous synced levels
  logic scl_s; // Synced SCL
  logic sda_s; // Synced SDA
  logic rise; // SCL rising
  logic fall; // SCL falling
  logic start; // Start or repeated start
  logic stop; // Stop condition
  logic [6:0] dev_ff; // Own address
  mcisd_st_e st_ff; // Byte engine state
  logic [3:0] cnt_ff; // Bit count in byte
  logic [7:0] sh_ff; // Shift register
  logic rd_dir_ff; // Read transfer
  logic ack_ff; // Master acknowledged
  logic sda_oe_ff; // Pull SDA low
  logic lo_ff; // Constant low pin level
  logic [9:0] str_ff; // Stretch cycles left
  logic [9:0] nxt_str; // Next stretch count
  logic scl_oe_ff; // Hold SCL low
  logic byte_done; // Eighth bit finished
  logic addr_hit; // Address matches
  logic stretch_go; // Begin a stretch
  logic [7:0] tx_byte; // Next byte to send
  logic [1:0] idx_ff; // Write byte index
  logic [7:0] cmd_ff; // Command byte
  logic [7:0] dlo_ff; // Duty low byte
  logic [7:0] off_ff; // Variable offset
  logic spc_ff; // RAM settings space
  mcisd_tgt_s tgt_ff; // Target output
  logic stop_ff; // Stop output
  mcisd_duty_s duty_ff; // Duty output
  mcisd_rdreq_s rdq_ff; // Read request
  logic [3:0] rdn_ff; // Bytes loaded this read

  ////////////////////////////////////////////////////////////
  // Pin synchroniser and bus events

  // Two flops per pin before anything looks at them
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sy1_ff <= 2'h3;
      sy2_ff <= 2'h3;
      prv_ff <= 2'h3;
    end else begin
      sy1_ff <= {sda_in, scl_in};
      sy2_ff <= sy1_ff;
      prv_ff <= sy2_ff;
    end
  end

  assign scl_s = sy2_ff[0];
  assign sda_s = sy2_ff[1];
  assign rise = scl_s && !prv_ff[0];
  assign fall = !scl_s && prv_ff[0];
  // SDA edges while SCL stays high
  assign start = scl_s && prv_ff[0] && prv_ff[1] && !sda_s;
  assign stop = scl_s && prv_ff[0] && !prv_ff[1] && sda_s;

  ////////////////////////////////////////////////////////////
  // Device number setting

  // Only the low 7 bits matter for I2C
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dev_ff <= 7'(`MCISD_DEV_NUM_RST);
    end else if (dev_num_wr) begin
      dev_ff <= dev_num_in[6:0];
    end
  end

  ////////////////////////////////////////////////////////////
  // Byte engine

  assign byte_done = fall && (cnt_ff == 4'h8) && (st_ff == ST_ADDR || st_ff == ST_RX);
  assign addr_hit = (sh_ff[7:1] == dev_ff);
  // Past the response limit the bus reads idle high
  assign tx_byte = (rdn_ff >= `MCISD_RD_MAX) ? 8'hFF : rd_data;

  // Start wins over everything, so a repeated start resyncs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      rd_dir_ff <= 1'b0;
      ack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (start) begin
      st_ff <= ST_ADDR;
      cnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
    end else if (stop) begin
      st_ff <= ST_IDLE;
      sda_oe_ff <= 1'b0;
    end else begin
      case (st_ff)
        ST_ADDR, ST_RX: begin
          // Sample on rise, decide after eighth fall
          if (rise && cnt_ff != 4'h8) begin
            sh_ff <= {sh_ff[6:0], sda_s};
            cnt_ff <= cnt_ff + 4'h1;
          end else if (byte_done) begin
            if (st_ff == ST_ADDR && !addr_hit) begin
              st_ff <= ST_IDLE;
            end else begin
              sda_oe_ff <= 1'b1;
              st_ff <= ST_ACK;
              if (st_ff == ST_ADDR) begin
                rd_dir_ff <= sh_ff[0];
              end
            end
          end
        end
        ST_ACK: begin
          // End of our ACK bit
          if (fall && rd_dir_ff) begin
            sh_ff <= tx_byte;
            sda_oe_ff <= !tx_byte[7];
            cnt_ff <= 4'h1;
            st_ff <= ST_TX;
          end else if (fall) begin
            sda_oe_ff <= 1'b0;
            cnt_ff <= 4'h0;
            st_ff <= ST_RX;
          end
        end
        ST_TX: begin
          // Next bit goes out while SCL is low
          if (fall && cnt_ff == 4'h8) begin
            sda_oe_ff <= 1'b0;
            st_ff <= ST_MACK;
          end else if (fall) begin
            sda_oe_ff <= !sh_ff[6];
            sh_ff <= {sh_ff[6:0], 1'b1};
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        ST_MACK: begin
          // NACK ends the read; wait for stop or start
          if (rise) begin
            ack_ff <= !sda_s;
          end else if (fall) begin
            st_ff <= ack_ff ? ST_LOAD : ST_IDLE;
          end
        end
        ST_LOAD: begin
          // Load in the first stretch cycle so SDA settles long before SCL is let go
          if (str_ff == 10'(STRETCH_CYC)) begin
            sh_ff <= tx_byte;
            sda_oe_ff <= !tx_byte[7];
            cnt_ff <= 4'h1;
            st_ff <= ST_TX;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  // Clock stretching

  // One stretch per byte: our ACK, or after a non-final read byte
  assign stretch_go = (byte_done && (st_ff == ST_RX || addr_hit))
                   || (st_ff == ST_MACK && fall && ack_ff);

  always_comb begin
    nxt_str = str_ff;
    if (start || stop) begin
      nxt_str = 10'h000;
    end else if (stretch_go) begin
      nxt_str = 10'(STRETCH_CYC);
    end else if (str_ff != 10'h000) begin
      nxt_str = str_ff - 10'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      str_ff <= 10'h000;
      scl_oe_ff <= 1'b0;
      lo_ff <= 1'b0;
    end else begin
      str_ff <= nxt_str;
      scl_oe_ff <= (nxt_str != 10'h000);
      lo_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // Write command decode

  // Action happens when the final byte is ACKed, not at stop
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      idx_ff <= 2'h0;
      cmd_ff <= 8'h00;
      dlo_ff <= 8'h00;
      off_ff <= 8'h00;
      spc_ff <= 1'b0;
      tgt_ff <= '0;
      stop_ff <= 1'b0;
      duty_ff <= '0;
    end else begin
      tgt_ff.valid <= 1'b0;
      stop_ff <= 1'b0;
      duty_ff.valid <= 1'b0;
      if (st_ff == ST_ADDR && byte_done) begin
        idx_ff <= 2'h0;
      end else if (st_ff == ST_RX && byte_done) begin
        idx_ff <= (idx_ff == 2'h3) ? 2'h3 : idx_ff + 2'h1;
        case (idx_ff)
          2'h0: begin
            cmd_ff <= sh_ff;
            // Offset kept if only the command follows
            if (sh_ff == `MCISD_CMD_GETVAR || sh_ff == `MCISD_CMD_GETRAM) begin
              spc_ff <= (sh_ff == `MCISD_CMD_GETRAM);
            end
          end
          2'h1: begin
            if (is_hires(cmd_ff)) begin
              tgt_ff <= {1'b1, sh_ff[6:0], cmd_ff[4:0]};
            end else if (cmd_ff == `MCISD_CMD_LOWFWD) begin
              tgt_ff <= {1'b1, low_tgt(1'b0, fb_mode, sh_ff[6:0])};
            end else if (cmd_ff == `MCISD_CMD_LOWREV) begin
              if (sh_ff[6:0] == 7'h00) begin
                stop_ff <= 1'b1;
              end else begin
                tgt_ff <= {1'b1, low_tgt(1'b1, fb_mode, sh_ff[6:0])};
              end
            end else if (is_duty(cmd_ff)) begin
              dlo_ff <= sh_ff;
            end else if (cmd_ff == `MCISD_CMD_GETVAR || cmd_ff == `MCISD_CMD_GETRAM) begin
              off_ff <= sh_ff;
            end
          end
          2'h2: begin
            if (is_duty(cmd_ff)) begin
              // High byte second
              duty_ff <= {1'b1, cmd_ff == `MCISD_CMD_FDUTYT, sh_ff, dlo_ff};
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Variable read pointer

  // Reads never clear anything; address walks upward
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdq_ff <= '0;
      rdn_ff <= 4'h0;
    end else if (st_ff == ST_ADDR && byte_done && addr_hit && sh_ff[0]) begin
      rdq_ff <= {spc_ff, off_ff};
      rdn_ff <= 4'h0;
    end else if (st_ff == ST_MACK && fall && ack_ff) begin
      rdq_ff.addr <= rdq_ff.addr + 8'h01;
    end else if ((st_ff == ST_ACK && fall && rd_dir_ff) || (st_ff == ST_LOAD && str_ff == 10'(STRETCH_CYC))) begin
      rdn_ff <= (rdn_ff == `MCISD_RD_MAX) ? rdn_ff : rdn_ff + 4'h1;
    end
  end

  assign scl_out = lo_ff;
  assign sda_out = lo_ff;
  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff;
  assign tgt_cmd = tgt_ff;
  assign stop_pulse = stop_ff;
  assign duty_cmd = duty_ff;
  assign rd_req = rdq_ff;

  ////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_foreign_addr: assert property (st_ff == ST_ADDR && byte_done && !addr_hit && !start && !stop
    |=> !sda_oe_ff && st_ff == ST_IDLE)
    else $error("foreign address answered");
  a_own_addr_ack: assert property (st_ff == ST_ADDR && byte_done && addr_hit && !start && !stop
    |=> sda_oe_ff && scl_oe_ff)
    else $error("own address not acked");
  a_hires_value: assert property (st_ff == ST_RX && byte_done && idx_ff == 2'h1 && is_hires(cmd_ff)
    && !start && !stop |=> tgt_ff.valid && tgt_ff.value == {$past(sh_ff[6:0]), cmd_ff[4:0]})
    else $error("high-res target wrong");
  a_fwd_scaled: assert property (tgt_ff.valid && $past(cmd_ff == `MCISD_CMD_LOWFWD)
    && fb_mode != FB_NONE && $past(fb_mode) != FB_NONE
    |-> tgt_ff.value == 12'h800 + {1'b0, $past(sh_ff[6:0]), 4'h0})
    else $error("forward target wrong");
  a_fwd_open: assert property (tgt_ff.valid && $past(cmd_ff == `MCISD_CMD_LOWFWD)
    && $past(fb_mode) == FB_NONE && $past(sh_ff[6:0]) == 7'h7F |-> tgt_ff.value == 12'h800 + 12'h258)
    else $error("open-loop full speed wrong");
  a_rev_stop: assert property (stop_ff |-> !tgt_ff.valid && $past(sh_ff[6:0]) == 7'h00
    && cmd_ff == `MCISD_CMD_LOWREV)
    else $error("stop without zero reverse");
  a_rev_below: assert property (tgt_ff.valid && cmd_ff == `MCISD_CMD_LOWREV |-> tgt_ff.value < 12'h800)
    else $error("reverse target above middle");
  a_duty_pair: assert property (duty_ff.valid |-> duty_ff.value[7:0] == dlo_ff
    && duty_ff.value[15:8] == $past(sh_ff) && duty_ff.hold == (cmd_ff == `MCISD_CMD_FDUTYT))
    else $error("duty bytes misordered");
  a_stretch_ends: assert property ($rose(scl_oe_ff) |-> ##[1:1000] !scl_oe_ff)
    else $error("stretch never released");
  a_rd_step: assert property (st_ff == ST_MACK && fall && ack_ff && !start && !stop
    |=> rd_req.addr == $past(rd_req.addr) + 8'h01)
    else $error("read address did not step");
  a_restart: assert property (start |=> st_ff == ST_ADDR && !sda_oe_ff)
    else $error("repeated start not resynced");

  c_tgt: cover property (tgt_ff.valid);
  c_duty: cover property (duty_ff.valid);
  c_read2: cover property (st_ff == ST_MACK && fall && ack_ff);
  c_stop: cover property (stop_ff);

endmodule : mcisd_top

// *** mcisd_top_test.sv ***
// Purpose: Self-checking bench for the motor command I2C slave decoder
// Assumes: Master model on the bus, variable memory modelled here
// Notes: Short stretch count keeps the run fast, yet outlasts the master's low phase
module mcisd_top_test
  import mcisd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // Design ports
  logic sys_clk, reset_n, scl_out, scl_oe, sda_out, sda_oe, dev_num_wr, stop_pulse;
  logic [13:0] dev_num_in;
  mcisd_fb_e fb_mode;
  mcisd_tgt_s tgt_cmd;
  mcisd_duty_s duty_cmd;
  mcisd_rdreq_s rd_req;
  logic [7:0] rd_data;
  // Bus wires and master drives
  logic scl, sda, m_scl_low, m_sda_low, hung;
  int stretch_cnt, fail_count, n_checks, n_tgt, n_stop, n_duty;
  logic [11:0] last_tgt;
  mcisd_duty_s last_duty;

  // Pull-ups: a wire is low while any party pulls it
  assign scl = ~(m_scl_low | (scl_oe & ~scl_out));
  assign sda = ~(m_sda_low | (sda_oe & ~sda_out));

  // Variable and RAM-settings memory, distinct pattern per space
  function automatic logic [7:0] mem_byte(input logic s, input logic [7:0] a);
    return s ? (a ^ 8'hA5) : (a + 8'h11);
  endfunction : mem_byte
  assign rd_data = mem_byte(rd_req.space, rd_req.addr);

  mcisd_top #(.STRETCH_CYC(8)) DUT (.sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .dev_num_wr(dev_num_wr),
    .dev_num_in(dev_num_in), .fb_mode(fb_mode), .tgt_cmd(tgt_cmd), .stop_pulse(stop_pulse),
    .duty_cmd(duty_cmd), .rd_req(rd_req), .rd_data(rd_data));

  mcisd_master m (.sys_clk(sys_clk), .scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low),
    .hung(hung), .stretch_cnt(stretch_cnt));

  //////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // Count command pulses; each lasts one cycle
  always @(posedge sys_clk) begin
    if (tgt_cmd.valid === 1'b1) begin
      n_tgt++;
      last_tgt = tgt_cmd.value;
    end
    if (stop_pulse === 1'b1) n_stop++;
    if (duty_cmd.valid === 1'b1) begin
      n_duty++;
      last_duty = duty_cmd;
    end
  end

  // A stuck clock stretch ends the run as a mismatch
  always @(posedge hung) begin
    fail_count++;
    $display("ERROR at %0t: bus hung %h expected %h", $time, 1'b1, 1'b0);
    stop_test();
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_ack(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: ack %h expected %h", $time, got, exp);
    end
  endtask : chk_ack

  // Start, write address then n bytes; no stop so callers can check first
  task automatic wr_cmd(input logic [6:0] a, input logic own, input logic [7:0] b [3], input int n);
    logic ak;
    int k;
    m.start();
    m.wr_byte({a, 1'b0}, ak);
    chk_ack(ak, own);
    for (k = 0; k < n; k++) begin
      m.wr_byte(b[k], ak);
      chk_ack(ak, own);
    end
  endtask : wr_cmd

  // Read transfer of n bytes; bytes past the fifteenth come back as 0xFF
  task automatic rd_check(input logic sp, input logic [7:0] off, input int n);
    logic ak;
    logic [7:0] d;
    int k;
    m.start();
    m.wr_byte(8'h17, ak);
    chk_ack(ak, 1'b1);
    for (k = 0; k < n; k++) begin
      m.rd_byte(k == n - 1, d);
      chk_val({8'h00, d}, {8'h00, (k < 15) ? mem_byte(sp, off + 8'(k)) : 8'hFF});
    end
    m.stop();
    m.idle_long();
  endtask : rd_check

  //////////////////////////////////////////////////////////////////////////////
  // High-resolution target at its ends and a middle value, plus stretch count
  task automatic t_hires();
    logic [11:0] tv [3];
    int k, bt, bs;
    tv = '{12'hC9D, 12'h000, 12'hFFF};
    for (k = 0; k < 3; k++) begin
      bt = n_tgt;
      bs = stretch_cnt;
      wr_cmd(7'h0B, 1'b1, '{8'hC0 | tv[k][4:0], {1'b0, tv[k][11:5]}, 8'h00}, 2);
      chk_val(16'(n_tgt - bt), 16'h0001);
      chk_val({4'h0, last_tgt}, {4'h0, tv[k]});
      m.stop();
      chk_val(16'(stretch_cnt - bs), 16'h0003);
    end
    $display("t_hires done");
  endtask : t_hires

  // Low-resolution forward and reverse in every feedback mode
  task automatic t_lowres();
    logic [7:0] mg [3];
    int fi, dir, mi, bt, bs, d;
    mg = '{8'h7F, 8'h05, 8'h00};
    for (fi = 0; fi < 3; fi++) for (dir = 0; dir < 2; dir++) for (mi = 0; mi < 3; mi++) begin
      @(posedge sys_clk);
      fb_mode <= mcisd_fb_e'(fi);
      bt = n_tgt;
      bs = n_stop;
      d = (fi == 0) ? (32'h0000_0258 * mg[mi]) / 32'h0000_007F : 32'h0000_0010 * mg[mi];
      wr_cmd(7'h0B, 1'b1, '{(dir == 1) ? 8'hE1 : 8'hE0, mg[mi], 8'h00}, 2);
      if (dir == 0 && mg[mi] == 8'h00) begin
        chk_val(16'(n_stop - bs), 16'h0001);
        chk_val(16'(n_tgt - bt), 16'h0000);
      end else begin
        chk_val(16'(n_tgt - bt), 16'h0001);
        chk_val({4'h0, last_tgt}, 16'((dir == 1) ? 32'h0000_0800 + d : 32'h0000_0800 - d));
        chk_val(16'(n_stop - bs), 16'h0000);
      end
      m.stop();
    end
    $display("t_lowres done");
  endtask : t_lowres

  // Both duty forcing commands, negative and positive limit-side values
  task automatic t_duty();
    int bd;
    bd = n_duty;
    wr_cmd(7'h0B, 1'b1, '{8'hF2, 8'hD4, 8'hFE}, 3);
    chk_val(16'(n_duty - bd), 16'h0001);
    chk_val(last_duty.value, 16'hFED4);
    chk_val({15'h0000, last_duty.hold}, 16'h0001);
    m.stop();
    bd = n_duty;
    wr_cmd(7'h0B, 1'b1, '{8'hF4, 8'h58, 8'h02}, 3);
    chk_val(16'(n_duty - bd), 16'h0001);
    chk_val(last_duty.value, 16'h0258);
    chk_val({15'h0000, last_duty.hold}, 16'h0000);
    m.stop();
    $display("t_duty done");
  endtask : t_duty

  // Variable reads: repeated start, RAM space past 15 bytes, command-only form
  task automatic t_read();
    wr_cmd(7'h0B, 1'b1, '{8'hE5, 8'h10, 8'h00}, 2);
    rd_check(1'b0, 8'h10, 4);
    wr_cmd(7'h0B, 1'b1, '{8'hEA, 8'h40, 8'h00}, 2);
    m.stop();
    rd_check(1'b1, 8'h40, 16);
    wr_cmd(7'h0B, 1'b1, '{8'hE5, 8'h20, 8'h00}, 2);
    m.stop();
    wr_cmd(7'h0B, 1'b1, '{8'hE5, 8'h00, 8'h00}, 1);
    rd_check(1'b0, 8'h20, 2);
    $display("t_read done");
  endtask : t_read

  // Foreign address ignored; a new device number moves the address
  task automatic t_addr();
    int bt, bs;
    bt = n_tgt;
    bs = stretch_cnt;
    wr_cmd(7'h30, 1'b0, '{8'hDD, 8'h64, 8'h00}, 2);
    m.stop();
    chk_val(16'(n_tgt - bt), 16'h0000);
    chk_val(16'(stretch_cnt - bs), 16'h0000);
    @(posedge sys_clk);
    dev_num_wr <= 1'b1;
    dev_num_in <= 14'h0123;
    @(posedge sys_clk);
    dev_num_wr <= 1'b0;
    wr_cmd(7'h23, 1'b1, '{8'hC1, 8'h02, 8'h00}, 2);
    m.stop();
    wr_cmd(7'h0B, 1'b0, '{8'hC2, 8'h02, 8'h00}, 2);
    m.stop();
    chk_val({4'h0, last_tgt}, 16'h0041);
    @(posedge sys_clk);
    dev_num_wr <= 1'b1;
    dev_num_in <= 14'h000B;
    @(posedge sys_clk);
    dev_num_wr <= 1'b0;
    $display("t_addr done");
  endtask : t_addr

  // Counts, then the verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  //////////////////////////////////////////////////////////////////////////////
  // Reset for 6 cycles, bus quiet for 3 edges after release
  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    dev_num_wr = 1'b0;
    dev_num_in = 14'h000B;
    fb_mode = FB_NONE;
    {fail_count, n_checks, n_tgt, n_stop, n_duty} = '0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk_val({14'h0000, scl_oe, sda_oe}, 16'h0000);
    t_hires();
    t_lowres();
    t_duty();
    t_read();
    t_addr();
    stop_test();
  end

endmodule : mcisd_top_test
